// >>> ccdst_pkg.sv
// Purpose: shared constants for the line/frame sync and clamp timing
// Assumes: one 125 MHz master clock, config written through cfg_* strobe
// Notes: register offsets are 8-bit control addresses
package ccdst_pkg;
   // control addresses
   localparam logic [7:0] CCDST_ADDR_CTRL = 8'h01;
   localparam logic [7:0] CCDST_ADDR_SYNC_PULSE_COUNT = 8'h0a;
   localparam logic [7:0] CCDST_ADDR_SLAVE = 8'hd6;
   // field positions inside the control word at 0x01
   localparam int CCDST_BIT_POL = 0;
   localparam int CCDST_BIT_CLP_ON = 1;
   localparam int CCDST_BIT_CLAMP_REGION_MODE = 2;
   // values after reset
   localparam logic CCDST_RST_SLAVE = 1'b1;
   localparam logic CCDST_RST_POL = 1'b0;
   localparam logic CCDST_RST_CLP_ON = 1'b0;
   localparam logic CCDST_RST_CLAMP_REGION_MODE = 1'b0;
   localparam logic [3:0] CCDST_RST_SYNC_PULSE_COUNT = 4'h0;
   // sync count codes
   localparam logic [3:0] CCDST_CNT_OFF = 4'h0;
   localparam logic [3:0] CCDST_CNT_EVERY = 4'h1;
   localparam logic [3:0] CCDST_CNT_ONCE = 4'hf;
   // setup delay added to every line, in master clock cycles
   localparam logic [12:0] CCDST_SETUP_CYC = 13'h0004;
   // widths
   localparam int CCDST_PIX_W = 12;
   localparam int CCDST_LINE_W = 11;
   localparam int CCDST_REF_W = 10;
   localparam int CCDST_REGIONS = 5;
endpackage

// >>> ccdst_gray_dec.sv
// Purpose: gray code to binary converter
// Assumes: purely combinational, any width
// Notes: used for the programmed gray-coded line lengths
`timescale 1ns/1ns
module ccdst_gray_dec #(
   parameter int WIDTH = 12
) (
   input wire logic [WIDTH-1:0] gray, // gray coded value
   output logic [WIDTH-1:0] bin // binary value
);
   // each binary bit is the xor of all gray bits at and above it
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign bin[i] = ^gray[WIDTH-1:i];
      end
   endgenerate
endmodule

// >>> ccdst_timing.sv
// Purpose: line sync, frame sync and black clamp pulse generator
// Assumes: master clock clk_sys, config strobes on the same clock
// Notes: line and last-line lengths in gray code; outputs lag the counters by one cycle
//
// Contract
// R1 - slave select written 0 makes the shared pin an external sync input.
// R2 - after reset the block is in slave mode, pin not used as sync.
// R3 - one polarity bit picks active low or active high sync input.
// R4 - sync polarity resets to active low.
// R5 - count 0 disables external sync; count 1 resyncs on every pulse.
// R6 - counts 2 to 14 resync after the Nth applied pulse.
// R7 - count 15 resyncs once on the first pulse, then ignores pulses.
// R8 - line sync goes low at the start of each line.
// R9 - frame sync goes low at the start of each frame's first line.
// R10 - 11-bit frame counter counts lines up to the frame length.
// R11 - 12-bit line counter counts pixels up to the line length; the pix counter here is 13 bits wide.
// R12 - 10-bit reference counter with programmable length times line sync rise.
// R13 - software writes line and last-line lengths as gray code.
// R14 - every line lasts four cycles more than its programmed length.
// R15 - 4-bit frame sync rise position compared against line counter; here it is compared against the frame counter line_cnt.
// R16 - last line of a frame uses its own gray-coded length.
// R17 - clamp on/off bit 0 suppresses the clamp pulse entirely.
// R18 - region mode 1 ignores region enables and clamps in all regions.
// R19 - five region enable bits each gate the clamp in their region.
// R20 - clamp toggles at two gray-coded pixel positions of the line counter.
// R21 - last line clamps only when last length equals line length.
// R22 - in slave mode the shared pin carries an external gate signal.
// R23 - region 0 begins at the frame sync fall; its enable still applies.
// R24 - line counter restarts each line; frame counter wraps at length.
// R25 - a qualifying sync pulse restarts frame and line counters.
`timescale 1ns/1ns
module ccdst_timing
   import ccdst_pkg::*;
(
   input wire logic clk_sys, // master pixel clock
   input wire logic arst_n, // async reset, active low
   input wire logic cfg_we, // control write strobe
   input wire logic [7:0] cfg_addr, // control address
   input wire logic [7:0] cfg_data, // control write data
   input wire logic [11:0] line_length, // gray coded
   input wire logic [9:0] line_ref_length, // reference period
   input wire logic [9:0] line_sync_rise_pos, // rise vs ref counter
   input wire logic [11:0] last_line_length, // gray coded
   input wire logic [10:0] frame_length, // lines per frame
   input wire logic [3:0] frame_sync_rise_pos, // rise line
   input wire logic [11:0] clamp_toggle_first, // gray position
   input wire logic [11:0] clamp_toggle_second, // gray position
   input wire logic [4:0] clamp_region_enable, // per region
   input wire logic [2:0] region_index, // active readout region
   input wire logic shared_sync_gate_pin, // pin, async
   output logic line_sync, // active low pulse
   output logic frame_sync, // active low pulse
   output logic black_clamp_pulse_n, // active low clamp
   output logic external_gate_signal, // gate latched at line start
   output logic master_mode // 1 while pin is sync input
);
   import ccdst_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // control registers

   logic slave_select;
   logic sync_input_polarity;
   logic clamp_on_off;
   logic clamp_region_mode;
   logic [3:0] sync_pulse_count;

   // R2 R4 reset defaults
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         slave_select <= CCDST_RST_SLAVE;
         sync_input_polarity <= CCDST_RST_POL;
         clamp_on_off <= CCDST_RST_CLP_ON;
         clamp_region_mode <= CCDST_RST_CLAMP_REGION_MODE;
         sync_pulse_count <= CCDST_RST_SYNC_PULSE_COUNT;
      end else if (cfg_we) begin
         case (cfg_addr)
            CCDST_ADDR_CTRL: begin
               sync_input_polarity <= cfg_data[CCDST_BIT_POL];
               clamp_on_off <= cfg_data[CCDST_BIT_CLP_ON];
               clamp_region_mode <= cfg_data[CCDST_BIT_CLAMP_REGION_MODE];
            end
            CCDST_ADDR_SYNC_PULSE_COUNT: begin
               sync_pulse_count <= cfg_data[3:0];
            end
            CCDST_ADDR_SLAVE: begin
               slave_select <= cfg_data[0];
            end
            default: begin
               slave_select <= slave_select;
            end
         endcase
      end
   end

   // mode status
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         master_mode <= 1'b0;
      end else begin
         master_mode <= ~slave_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared pin synchroniser

   logic pin_s1;
   logic pin_s2;
   logic pin_s3;
   logic pin_level;
   logic pin_active_d;
   logic pin_level_d;
   logic pin_active;
   logic sync_edge;

   // three stages, level accepted when stages two and three agree
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_s3 <= 1'b1;
         pin_level <= 1'b1;
      end else begin
         pin_s1 <= shared_sync_gate_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3) begin
            pin_level <= pin_s3;
         end
      end
   end

   // R3 polarity select
   assign pin_active = sync_input_polarity ? pin_level : ~pin_level;

   // previous level kept raw, so a polarity write makes no false edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_level_d <= 1'b1;
      end else begin
         pin_level_d <= pin_level;
      end
   end

   assign pin_active_d = sync_input_polarity ? pin_level_d : ~pin_level_d;

   // R1 sync pulses only in master mode
   assign sync_edge = ~slave_select & pin_active & ~pin_active_d;

   ////////////////////////////////////////////////////////////////////////
   // sync pulse counting

   logic [3:0] pulse_cnt;
   logic once_done;
   logic resync;
   logic [3:0] pulse_cnt_inc;

   assign pulse_cnt_inc = pulse_cnt + 4'h1;

   // R5 R6 R7 decide which pulse realigns the frame
   always_comb begin
      resync = 1'b0;
      if (sync_edge) begin
         case (sync_pulse_count)
            CCDST_CNT_OFF: resync = 1'b0;
            CCDST_CNT_EVERY: resync = 1'b1;
            CCDST_CNT_ONCE: resync = ~once_done;
            default: resync = (pulse_cnt_inc == sync_pulse_count);
         endcase
      end
   end

   // pulse tally, cleared on each realignment or outside master mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pulse_cnt <= 4'h0;
      end else if (slave_select || resync) begin
         pulse_cnt <= 4'h0;
      end else if (sync_edge) begin
         pulse_cnt <= pulse_cnt_inc;
      end
   end

   // R7 one-shot memory, rearmed by leaving master mode or new count
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         once_done <= 1'b0;
      end else if (slave_select || sync_pulse_count != CCDST_CNT_ONCE) begin
         once_done <= 1'b0;
      end else if (resync) begin
         once_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line, reference and frame counters

   logic [11:0] len_bin;
   logic [11:0] last_bin;
   logic [12:0] pix;
   logic [9:0] ref_cnt;
   logic [10:0] line_cnt;
   logic [10:0] last_idx;
   logic last_line;
   logic [12:0] line_end;
   logic pix_end;

   // R13 lengths arrive gray coded
   ccdst_gray_dec #(.WIDTH(CCDST_PIX_W)) u_len_dec (
      .gray(line_length),
      .bin(len_bin)
   );

   ccdst_gray_dec #(.WIDTH(CCDST_PIX_W)) u_last_dec (
      .gray(last_line_length),
      .bin(last_bin)
   );

   // a zero frame length behaves as a single line
   assign last_idx = (frame_length == 11'h000) ? 11'h000 :
                     frame_length - 11'h001;
   assign last_line = (line_cnt == last_idx);

   // R14 R16 line lasts programmed length plus setup
   assign line_end = (last_line ? {1'b0, last_bin} : {1'b0, len_bin}) +
                     CCDST_SETUP_CYC - 13'h0001;
   assign pix_end = (pix >= line_end);

   // R11 R24 R25 pixel counter
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pix <= 13'h0000;
      end else if (resync || pix_end) begin
         pix <= 13'h0000;
      end else begin
         pix <= pix + 13'h0001;
      end
   end

   // R12 reference counter, restarted with every line
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ref_cnt <= 10'h000;
      end else if (resync || pix_end || ref_cnt >= line_ref_length) begin
         ref_cnt <= 10'h000;
      end else begin
         ref_cnt <= ref_cnt + 10'h001;
      end
   end

   // R10 R24 R25 frame counter
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line_cnt <= 11'h000;
      end else if (resync) begin
         line_cnt <= 11'h000;
      end else if (pix_end) begin
         line_cnt <= last_line ? 11'h000 : line_cnt + 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync outputs

   logic line_start;

   assign line_start = (pix == 13'h0000);

   // R8 R12 line sync low at line start, high at rise position
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line_sync <= 1'b1;
      end else if (line_start) begin
         line_sync <= 1'b0;
      end else if (ref_cnt == line_sync_rise_pos) begin
         line_sync <= 1'b1;
      end
   end

   // R9 R15 frame sync low on first line, high at rise line
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         frame_sync <= 1'b1;
      end else if (line_start && line_cnt == 11'h000) begin
         frame_sync <= 1'b0;
      end else if (line_start && line_cnt == {7'h00, frame_sync_rise_pos}) begin
         frame_sync <= 1'b1;
      end
   end

   // R22 gate input latched at each line start while in slave mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         external_gate_signal <= 1'b0;
      end else if (slave_select && line_start) begin
         external_gate_signal <= pin_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // black clamp pulse

   logic [11:0] pix_gray;
   logic [2:0] region_eff;
   logic region_ok;
   logic clamp_ok;

   // R20 compare positions against the gray coded count
   assign pix_gray = pix[11:0] ^ {1'b0, pix[11:1]};

   // R23 first line of a frame is always region 0
   assign region_eff = (line_cnt == 11'h000) ? 3'h0 : region_index;

   // R18 R19 region gating
   assign region_ok = clamp_region_mode |
                      ((region_eff < 3'h5) & clamp_region_enable[region_eff]);

   // R17 R21 master switch and last line length match
   assign clamp_ok = clamp_on_off & region_ok &
                     (~last_line | (last_line_length == line_length));

   // R20 clamp low between the two toggle positions
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         black_clamp_pulse_n <= 1'b1;
      end else if (line_start || !clamp_ok) begin
         black_clamp_pulse_n <= 1'b1;
      end else if (pix_gray == clamp_toggle_first) begin
         black_clamp_pulse_n <= 1'b0;
      end else if (pix_gray == clamp_toggle_second) begin
         black_clamp_pulse_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_line_start_low: assert property ( // R8
      @(posedge clk_sys) disable iff (!arst_n)
      line_start |=> !line_sync)
      else $error("line sync not low at line start");

   a_frame_start_low: assert property ( // R9
      @(posedge clk_sys) disable iff (!arst_n)
      line_start && line_cnt == 11'h000 |=> !frame_sync)
      else $error("frame sync not low at frame start");

   a_slave_no_sync: assert property ( // R1
      @(posedge clk_sys) disable iff (!arst_n)
      slave_select |-> !resync)
      else $error("resync seen in slave mode");

   a_count_off: assert property ( // R5
      @(posedge clk_sys) disable iff (!arst_n)
      sync_pulse_count == CCDST_CNT_OFF |-> !resync)
      else $error("resync with sync disabled");

   a_once_only: assert property ( // R7
      @(posedge clk_sys) disable iff (!arst_n)
      sync_pulse_count == CCDST_CNT_ONCE && once_done |-> !resync)
      else $error("second resync with one-shot count");

   a_nth_pulse: assert property ( // R6
      @(posedge clk_sys) disable iff (!arst_n)
      resync && sync_pulse_count > 4'h1 && sync_pulse_count < 4'hf
      |-> pulse_cnt == sync_pulse_count - 4'h1)
      else $error("resync on wrong pulse");

   a_resync_restart: assert property ( // R25
      @(posedge clk_sys) disable iff (!arst_n)
      resync |=> pix == 13'h0000 && line_cnt == 11'h000 && ref_cnt == 10'h000)
      else $error("counters not restarted on resync");

   a_line_length: assert property ( // R14
      @(posedge clk_sys) disable iff (!arst_n)
      !resync && !last_line && pix == {1'b0, len_bin} + 13'h0003
      |=> pix == 13'h0000)
      else $error("line length not programmed plus four");

   a_clamp_off: assert property ( // R17
      @(posedge clk_sys) disable iff (!arst_n)
      !clamp_on_off |=> black_clamp_pulse_n)
      else $error("clamp pulse while switched off");

   a_last_clamp: assert property ( // R21
      @(posedge clk_sys) disable iff (!arst_n)
      last_line && last_line_length != line_length |=> black_clamp_pulse_n)
      else $error("clamp in mismatched last line");

   a_frame_wrap: assert property ( // R10
      @(posedge clk_sys) disable iff (!arst_n)
      !resync && pix_end && last_line |=> line_cnt == 11'h000)
      else $error("frame counter did not wrap");
endmodule

// >>> ccdst_sync_src.sv
// Purpose: external sync source driving the shared sync/gate pin
// Assumes: pin changes on falling clock edges only
// Notes: pulse is the inverse of the idle level, four cycles each level
`timescale 1ns/1ns
module ccdst_sync_src (
   input wire logic clk_sys, // master clock
   output logic pin // shared sync/gate pin
);
   logic idle; // inactive level of the pin
   ////////////////////////////////////////////////////////////////////
   // pin idles high, the inactive level for active-low sync
   initial begin
      idle = 1'b1;
      pin = 1'b1;
   end
   // steady level, also serves as the gate input
   task automatic hold(input logic v);
      @(negedge clk_sys);
      idle = v;
      pin = v;
   endtask
   // one active pulse, both levels held well past the filter
   task automatic pulse();
      @(negedge clk_sys);
      pin = ~idle;
      repeat (4) @(negedge clk_sys);
      pin = idle;
      repeat (4) @(negedge clk_sys);
   endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the sync and clamp timing block
// Assumes: inputs change on falling edges, 8 ns clock
// Notes: line of 12 plus setup, three lines per frame
`timescale 1ns/1ns
module tb;
   import ccdst_pkg::*;
   logic clk_sys, arst_n, cfg_we, pin;
   logic [7:0] cfg_addr, cfg_data;
   logic [11:0] line_length, last_line_length;
   logic [11:0] clamp_toggle_first, clamp_toggle_second;
   logic [9:0] line_ref_length, line_sync_rise_pos;
   logic [10:0] frame_length;
   logic [3:0] frame_sync_rise_pos;
   logic [4:0] clamp_region_enable;
   logic [2:0] region_index;
   logic line_sync, frame_sync, black_clamp_pulse_n;
   logic external_gate_signal, master_mode;
   int bad_count = 0;
   int n_tests = 0;
   int lp;
   ////////////////////////////////////////////////////////////////////
   ccdst_timing DUT (.clk_sys(clk_sys), .arst_n(arst_n),
      .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
      .line_length(line_length), .line_ref_length(line_ref_length),
      .line_sync_rise_pos(line_sync_rise_pos),
      .last_line_length(last_line_length), .frame_length(frame_length),
      .frame_sync_rise_pos(frame_sync_rise_pos),
      .clamp_toggle_first(clamp_toggle_first),
      .clamp_toggle_second(clamp_toggle_second),
      .clamp_region_enable(clamp_region_enable),
      .region_index(region_index), .shared_sync_gate_pin(pin),
      .line_sync(line_sync), .frame_sync(frame_sync),
      .black_clamp_pulse_n(black_clamp_pulse_n),
      .external_gate_signal(external_gate_signal),
      .master_mode(master_mode));
   ccdst_sync_src u_src (.clk_sys(clk_sys), .pin(pin));
   ////////////////////////////////////////////////////////////////////
   // lengths in gray code
   function automatic logic [11:0] gry(input int b);
      return 12'(b ^ (b >> 1));
   endfunction
   function automatic logic sel(input int w);
      case (w)
         0: return line_sync;
         1: return frame_sync;
         default: return black_clamp_pulse_n;
      endcase
   endfunction
   task automatic check(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic check_n(input string nm, input int e, input int g);
      n_tests++;
      if (g != e) begin
         bad_count++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      cfg_we = 1'b1;
      cfg_addr = a;
      cfg_data = d;
      @(negedge clk_sys);
      cfg_we = 1'b0;
   endtask
   task automatic wait_lvl(input int w, input logic v, input int lim,
                           output int n);
      n = 0;
      while (sel(w) !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask
   task automatic fall(input int w);
      int d, f;
      wait_lvl(w, 1'b1, 600, d);
      wait_lvl(w, 1'b0, 600, f);
      check_n("edge wait", 1, int'(d < 600 && f < 600));
   endtask
   task automatic period(input int w, output int n);
      int a, b;
      fall(w);
      wait_lvl(w, 1'b1, 600, a);
      wait_lvl(w, 1'b0, 600, b);
      n = a + b;
   endtask
   // pulse mid-frame, frame sync falls soon only on a resync
   task automatic try(input logic e);
      int n;
      fall(1);
      repeat (20) @(posedge clk_sys);
      u_src.pulse();
      wait_lvl(1, 1'b0, 8, n);
      check("resync", e, sel(1) === 1'b0);
   endtask
   task automatic cl(input logic [7:0] c, input logic [4:0] en,
                     input int last, input int e);
      int n, i, p;
      p = 2 * lp + last + int'(CCDST_SETUP_CYC);
      wr(CCDST_ADDR_CTRL, c);
      clamp_region_enable = en;
      last_line_length = gry(last);
      period(1, n);
      check_n("frame period", p, n);
      n = 0;
      for (i = 0; i < p; i++) begin
         if (sel(2) === 1'b0) n++;
         @(posedge clk_sys);
         #1;
      end
      check_n("clamp cycles", e, n);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      int n;
      check("master_mode", 1'b0, master_mode);
      wr(8'h55, 8'h00);
      repeat (3) @(negedge clk_sys);
      check("master_mode", 1'b0, master_mode);
      period(0, n);
      check_n("line period", lp, n);
      period(1, n);
      check_n("frame period", 3 * lp, n);
      fall(1);
      wait_lvl(1, 1'b1, 600, n);
      check_n("frame low", lp, n);
      fall(0);
      wait_lvl(0, 1'b1, 600, n);
      check_n("line low", 2, n);
      $display("test defaults done");
   endtask
   task automatic t_slave();
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h01);
      try(1'b0);
      u_src.hold(1'b1);
      repeat (40) @(negedge clk_sys);
      check("gate", 1'b1, external_gate_signal);
      u_src.hold(1'b0);
      repeat (40) @(negedge clk_sys);
      check("gate", 1'b0, external_gate_signal);
      u_src.hold(1'b1);
      $display("test slave done");
   endtask
   task automatic t_sync();
      int c;
      wr(CCDST_ADDR_SLAVE, 8'h00);
      repeat (3) @(negedge clk_sys);
      check("master_mode", 1'b1, master_mode);
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h00);
      try(1'b0);
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h01);
      try(1'b1);
      try(1'b1);
      for (int k = 0; k < 2; k++) begin
         c = k ? 14 : 3;
         wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'(c));
         for (int i = 1; i < c; i++) try(1'b0);
         try(1'b1);
      end
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h0f);
      try(1'b1);
      try(1'b0);
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h00);
      wr(CCDST_ADDR_CTRL, 8'h01);
      u_src.hold(1'b0);
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h01);
      try(1'b1);
      wr(CCDST_ADDR_SLAVE, 8'h01);
      wr(CCDST_ADDR_SYNC_PULSE_COUNT, 8'h00);
      u_src.hold(1'b1);
      $display("test sync done");
   endtask
   task automatic t_clamp();
      cl(8'h00, 5'h1f, 12, 0);
      cl(8'h06, 5'h00, 12, 15);
      cl(8'h02, 5'h00, 12, 0);
      cl(8'h02, 5'h1f, 12, 15);
      cl(8'h02, 5'h01, 12, 5);
      cl(8'h02, 5'h08, 12, 10);
      cl(8'h06, 5'h1f, 20, 10);
      cl(8'h06, 5'h1f, 8, 10);
      $display("test clamp done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // clock, 8 ns period
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // watchdog well beyond the few thousand cycles expected
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      complete_run();
   end
   // main sequence
   initial begin
      lp = 12 + int'(CCDST_SETUP_CYC);
      arst_n = 1'b0;
      cfg_we = 1'b0;
      cfg_addr = 8'h00;
      cfg_data = 8'h00;
      line_length = gry(12);
      last_line_length = gry(12);
      line_ref_length = 10'h00f;
      line_sync_rise_pos = 10'h002;
      frame_length = 11'h003;
      frame_sync_rise_pos = 4'h1;
      clamp_toggle_first = gry(3);
      clamp_toggle_second = gry(8);
      clamp_region_enable = 5'h1f;
      region_index = 3'h3;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      t_defaults();
      t_slave();
      t_sync();
      t_clamp();
      complete_run();
   end
endmodule
